// ---- csc_cfg.svh ----
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH

// Register byte offsets
`define CSC_OFF_STATUS      8'h00
`define CSC_OFF_CHANGE      8'h04
`define CSC_OFF_CHG_EN      8'h08
`define CSC_OFF_CONTROL     8'h0C
`define CSC_OFF_CYCLE       8'h10

// Status field positions
`define CSC_ST_CD_A         0
`define CSC_ST_CD_B         1
`define CSC_ST_PRESENT      2
`define CSC_ST_BATT_LO      3
`define CSC_ST_BATT_HI      4
`define CSC_ST_READY        5
`define CSC_ST_BVD_A        6
`define CSC_ST_BVD_B        7
`define CSC_ST_ALERT        8
`define CSC_ST_RING         9
`define CSC_ST_AUDIO        10
`define CSC_ST_ACK          11
`define CSC_ST_BUSY         12

// Change and enable bit positions
`define CSC_CH_BVD_A        0
`define CSC_CH_BVD_B        1
`define CSC_CH_READY        2
`define CSC_CH_DETECT       3

// Control bit positions
`define CSC_CT_IO_MODE      0
`define CSC_CT_MODEM        1
`define CSC_CT_AUDIO_EN     2

// Cycle command bit positions
`define CSC_CY_ADDR_LSB     0
`define CSC_CY_WIDE         1
`define CSC_CY_IO_READ      2

// Reset values
`define CSC_CHANGE_RST      4'h0
`define CSC_CHG_EN_RST      4'h0
`define CSC_CONTROL_RST     3'h0
`define CSC_CYCLE_RST       2'h0
`define CSC_SYNC_RST        6'h3F

// Timing
`define CSC_CLK_PERIOD_NS   8
`define CSC_SETUP_NS        16
`define CSC_STROBE_NS       80

`endif

// ---- csc_pkg.sv ----
package csc_pkg;

    typedef enum logic [2:0] {
        CSC_IDLE   = 3'b001,
        CSC_SETUP  = 3'b010,
        CSC_STROBE = 3'b100
    } csc_cycle_e;

    typedef enum logic [1:0] {
        CSC_BATT_GOOD = 2'b00,
        CSC_BATT_WEAK = 2'b01,
        CSC_BATT_LOST = 2'b10
    } csc_batt_e;

    typedef logic [2:0] csc_regsel_t;

endpackage

// ---- csc_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

module csc_sync #(
    parameter int           W         = 6,
    parameter logic [W-1:0] RESET_VAL = '1
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    // Asynchronous lines in, filtered level out
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] stable_out
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] stable_next;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // Level accepted once stages two and three agree
            assign stable_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : stable_out[g];
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg     <= RESET_VAL;
            s2_reg     <= RESET_VAL;
            s3_reg     <= RESET_VAL;
            stable_out <= RESET_VAL;
        end else begin
            s1_reg     <= async_in;
            s2_reg     <= s1_reg;
            s3_reg     <= s2_reg;
            stable_out <= stable_next;
        end
    end

endmodule

`default_nettype wire

// ---- csc_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "csc_cfg.svh"

// Function
// [RULE_01] In memory mode the battery decodes as good when both lines are high, weak when only the second is low, lost when the first is low.
// [RULE_02] A battery-backed memory card drives both battery lines to show its battery condition.
// [RULE_03] Battery line levels are readable status and change flags, each change source with its own enable.
// [RULE_04] In I/O mode the first battery line is a status-change alert and its changes are change events.
// [RULE_05] With a modem card configured the first battery line, when low, reads as ring indication.
// [RULE_06] The second battery line passes as the audio bit only in I/O mode.
// [RULE_07] Both card-detect lines low means a card is present, and both lines are readable.
// [RULE_08] The first byte enable selects even bytes and the second selects odd bytes.
// [RULE_09] The card asserts input acknowledge only when it can answer the I/O read at the current address.
// [RULE_10] The I/O read strobe is driven low to let an I/O card put out data during an I/O read.
// [RULE_11] In memory mode the ready line is watched, low meaning busy, and its changes are flagged.
// [RULE_12] Every card-side status input is synchronised before decoding or change detection.
// [RULE_13] A changed status input sets a sticky flag and an enabled flag raises the interrupt.
module csc_top #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Card status pins
    input  wire logic        battery_detect_a,
    input  wire logic        battery_detect_b,
    input  wire logic        card_detect_a,
    input  wire logic        card_detect_b,
    input  wire logic        card_ready,
    input  wire logic        input_acknowledge_n,
    // Card control pins
    output var  logic        even_byte_enable_n,
    output var  logic        odd_byte_enable_n,
    output var  logic        io_read_strobe_n,
    output var  logic        audio_out_bit,
    output var  logic        chg_irq
);

    localparam int SETUP_CYC  = (`CSC_SETUP_NS + `CSC_CLK_PERIOD_NS - 1) / `CSC_CLK_PERIOD_NS;
    localparam int STROBE_CYC = (`CSC_STROBE_NS + `CSC_CLK_PERIOD_NS - 1) / `CSC_CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] SETUP_LOAD  = CNT_W'(SETUP_CYC - 1);
    localparam logic [CNT_W-1:0] STROBE_LOAD = CNT_W'(STROBE_CYC - 1);
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic csc_pkg::csc_regsel_t reg_index(input logic [7:0] a);
        if (a == `CSC_OFF_STATUS)       reg_index = 3'd0;
        else if (a == `CSC_OFF_CHANGE)  reg_index = 3'd1;
        else if (a == `CSC_OFF_CHG_EN)  reg_index = 3'd2;
        else if (a == `CSC_OFF_CONTROL) reg_index = 3'd3;
        else if (a == `CSC_OFF_CYCLE)   reg_index = 3'd4;
        else                            reg_index = 3'd7;
    endfunction

    function automatic csc_pkg::csc_batt_e batt_decode(input logic a, input logic b);
        if (!a)      batt_decode = csc_pkg::CSC_BATT_LOST;
        else if (!b) batt_decode = csc_pkg::CSC_BATT_WEAK;
        else         batt_decode = csc_pkg::CSC_BATT_GOOD;
    endfunction

    // Synchronised pins: bvd_a, bvd_b, cd_a, cd_b, ready, ack_n
    logic [5:0] pin_s;
    logic [5:0] prev_reg;

    csc_sync #(
        .W         (6),
        .RESET_VAL (`CSC_SYNC_RST)
    ) u_sync (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .async_in   ({input_acknowledge_n, card_ready, card_detect_b, card_detect_a,
                      battery_detect_b, battery_detect_a}), // RULE_12
        .stable_out (pin_s)
    );

    wire bvd_a_s = pin_s[0];
    wire bvd_b_s = pin_s[1];
    wire cd_a_s  = pin_s[2];
    wire cd_b_s  = pin_s[3];
    wire rdy_s   = pin_s[4];
    wire ack_n_s = pin_s[5];

    // Registers
    logic [3:0]          change_reg;
    logic [3:0]          chg_en_reg;
    logic [2:0]          control_reg;
    logic [1:0]          cycle_reg;
    logic                ack_seen_reg;
    csc_pkg::csc_cycle_e state_reg;
    logic [CNT_W-1:0]    cnt_reg;
    logic                aw_full_reg;
    logic                w_full_reg;
    logic [7:0]          awaddr_reg;
    logic [31:0]         wdata_reg;
    logic                wstrb0_reg;

    wire io_mode  = control_reg[`CSC_CT_IO_MODE];
    wire modem    = control_reg[`CSC_CT_MODEM];
    wire audio_en = control_reg[`CSC_CT_AUDIO_EN];

    // Status decode
    wire csc_pkg::csc_batt_e batt_w = io_mode ? csc_pkg::CSC_BATT_GOOD
                                              : batt_decode(bvd_a_s, bvd_b_s); // RULE_01
    wire present_w = !cd_a_s && !cd_b_s; // RULE_07
    wire alert_w   = io_mode && !modem && !bvd_a_s; // RULE_04
    wire ring_w    = io_mode && modem && !bvd_a_s; // RULE_05
    wire audio_w   = io_mode && audio_en && bvd_b_s; // RULE_06
    wire busy_w    = state_reg != csc_pkg::CSC_IDLE;

    wire [31:0] status_w = {19'h0_0000, busy_w, ack_seen_reg, audio_w, ring_w, alert_w,
                            bvd_b_s, bvd_a_s, rdy_s, batt_w, present_w, cd_b_s, cd_a_s}; // RULE_03

    // Change events
    wire [3:0] event_w = {(pin_s[2] != prev_reg[2]) || (pin_s[3] != prev_reg[3]),
                          (pin_s[4] != prev_reg[4]) && !io_mode, // RULE_11
                          pin_s[1] != prev_reg[1],
                          pin_s[0] != prev_reg[0]}; // RULE_04

    // AXI write path
    wire aw_hs    = s_axi_awvalid && s_axi_awready;
    wire w_hs     = s_axi_wvalid && s_axi_wready;
    wire wr_fire  = aw_full_reg && w_full_reg && !s_axi_bvalid;
    wire csc_pkg::csc_regsel_t wsel = reg_index(awaddr_reg);
    wire wr_ok    = wsel != 3'd7;
    wire wr_lane  = wr_fire && wstrb0_reg;
    wire aw_full_next = (aw_full_reg || aw_hs) && !wr_fire;
    wire w_full_next  = (w_full_reg || w_hs) && !wr_fire;
    wire bvalid_next  = wr_fire || (s_axi_bvalid && !s_axi_bready);

    wire [3:0] chg_clr  = (wr_lane && wsel == 3'd1) ? wdata_reg[3:0] : 4'h0;
    // Set wins over clear
    wire [3:0] change_next = (change_reg & ~chg_clr) | event_w; // RULE_13
    wire [3:0] chg_en_next = (wr_lane && wsel == 3'd2) ? wdata_reg[3:0] : chg_en_reg; // RULE_03
    wire [2:0] control_next = (wr_lane && wsel == 3'd3) ? wdata_reg[2:0] : control_reg;
    wire start_w = wr_lane && wsel == 3'd4 && wdata_reg[`CSC_CY_IO_READ] && !busy_w;
    wire [1:0] cycle_next = start_w ? wdata_reg[1:0] : cycle_reg;

    // AXI read path
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire csc_pkg::csc_regsel_t rsel = reg_index(s_axi_araddr);
    wire rvalid_next = ar_hs || (s_axi_rvalid && !s_axi_rready);
    wire [31:0] rd_mux = (rsel == 3'd0) ? status_w
                       : (rsel == 3'd1) ? {28'h000_0000, change_reg}
                       : (rsel == 3'd2) ? {28'h000_0000, chg_en_reg}
                       : (rsel == 3'd3) ? {29'h0000_0000, control_reg}
                       : (rsel == 3'd4) ? {30'h0000_0000, cycle_reg}
                       : 32'h0000_0000;

    // I/O read cycle sequencer
    csc_pkg::csc_cycle_e state_next;
    logic [CNT_W-1:0]    cnt_next;
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            csc_pkg::CSC_IDLE: begin
                if (start_w) begin
                    state_next = csc_pkg::CSC_SETUP;
                    cnt_next   = SETUP_LOAD;
                end
            end
            csc_pkg::CSC_SETUP: begin
                if (cnt_reg == '0) begin
                    state_next = csc_pkg::CSC_STROBE;
                    cnt_next   = STROBE_LOAD;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            csc_pkg::CSC_STROBE: begin
                if (cnt_reg == '0) begin
                    state_next = csc_pkg::CSC_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = csc_pkg::CSC_IDLE;
                cnt_next   = '0;
            end
        endcase
    end

    wire idle_next  = state_next == csc_pkg::CSC_IDLE;
    wire even_next  = idle_next || (!cycle_next[`CSC_CY_WIDE] && cycle_next[`CSC_CY_ADDR_LSB]);
    wire odd_next   = idle_next || (!cycle_next[`CSC_CY_WIDE] && !cycle_next[`CSC_CY_ADDR_LSB]);
    wire strobe_next = state_next != csc_pkg::CSC_STROBE; // RULE_10
    wire ack_next   = start_w ? 1'b0
                    : (ack_seen_reg || (state_reg == csc_pkg::CSC_STROBE && !ack_n_s));
    wire irq_next   = |(change_reg & chg_en_reg); // RULE_13

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            change_reg  <= `CSC_CHANGE_RST;
            chg_en_reg  <= `CSC_CHG_EN_RST;
            control_reg <= `CSC_CONTROL_RST;
            cycle_reg   <= `CSC_CYCLE_RST;
            prev_reg    <= `CSC_SYNC_RST;
            ack_seen_reg <= 1'b0;
            state_reg   <= csc_pkg::CSC_IDLE;
            cnt_reg     <= '0;
        end else begin
            change_reg  <= change_next;
            chg_en_reg  <= chg_en_next;
            control_reg <= control_next;
            cycle_reg   <= cycle_next;
            prev_reg    <= pin_s;
            ack_seen_reg <= ack_next;
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            even_byte_enable_n <= 1'b1;
            odd_byte_enable_n  <= 1'b1;
            io_read_strobe_n   <= 1'b1;
            audio_out_bit      <= 1'b0;
            chg_irq            <= 1'b0;
        end else begin
            even_byte_enable_n <= even_next; // RULE_08
            odd_byte_enable_n  <= odd_next;
            io_read_strobe_n   <= strobe_next;
            audio_out_bit      <= audio_w; // RULE_06
            chg_irq            <= irq_next;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= 32'h0000_0000;
            wstrb0_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            aw_full_reg   <= aw_full_next;
            w_full_reg    <= w_full_next;
            s_axi_awready <= !aw_full_next;
            s_axi_wready  <= !w_full_next;
            s_axi_bvalid  <= bvalid_next;
            s_axi_arready <= !rvalid_next;
            s_axi_rvalid  <= rvalid_next;
            if (aw_hs) awaddr_reg <= s_axi_awaddr;
            if (w_hs) begin
                wdata_reg  <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            if (ar_hs) begin
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= (rsel != 3'd7) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    chk_batt_weak: assert property ( // RULE_01
        ar_hs && rsel == 3'd0 && !io_mode && bvd_a_s && !bvd_b_s
        |=> s_axi_rdata[`CSC_ST_BATT_HI:`CSC_ST_BATT_LO] == csc_pkg::CSC_BATT_WEAK)
        else $error("weak battery not reported");
    chk_w1c_clear: assert property ( // RULE_03
        wr_lane && wsel == 3'd1 && wdata_reg[0] && !event_w[0] |=> !change_reg[0])
        else $error("change flag not cleared by write");
    chk_io_alert: assert property ( // RULE_04
        io_mode && $changed(bvd_a_s) |=> change_reg[`CSC_CH_BVD_A])
        else $error("alert edge not flagged");
    chk_ring_read: assert property ( // RULE_05
        ar_hs && rsel == 3'd0 && io_mode && modem && !bvd_a_s |=> s_axi_rdata[`CSC_ST_RING])
        else $error("ring indication missing");
    chk_audio_gate: assert property ( // RULE_06
        !io_mode |=> !audio_out_bit)
        else $error("audio bit outside I/O mode");
    chk_card_present: assert property ( // RULE_07
        ar_hs && rsel == 3'd0 && !cd_a_s && !cd_b_s |=> s_axi_rdata[`CSC_ST_PRESENT])
        else $error("inserted card not reported");
    chk_even_lane: assert property ( // RULE_08
        !io_read_strobe_n && !cycle_reg[`CSC_CY_WIDE]
        |-> (even_byte_enable_n == cycle_reg[0]) && (odd_byte_enable_n != cycle_reg[0]))
        else $error("byte enable lane wrong");
    chk_strobe_len: assert property ( // RULE_10
        $fell(io_read_strobe_n) |-> !io_read_strobe_n [*8] ##1 !io_read_strobe_n ##1
        !io_read_strobe_n ##1 io_read_strobe_n)
        else $error("read strobe width wrong");
    chk_ready_flag: assert property ( // RULE_11
        !io_mode && $changed(rdy_s) |=> change_reg[`CSC_CH_READY])
        else $error("ready change not flagged");
    chk_irq_gate: assert property ( // RULE_13
        (change_reg & chg_en_reg) != 4'h0 |=> chg_irq)
        else $error("enabled change without interrupt");

    cov_io_read_ack: cover property (state_reg == csc_pkg::CSC_STROBE && !ack_n_s);
    cov_insert: cover property ($fell(cd_a_s || cd_b_s));
    cov_irq: cover property ($rose(chg_irq));

endmodule

`default_nettype wire

// ---- csc_card_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module csc_card_model (
    // Socket side
    input  wire logic even_byte_enable_n,
    input  wire logic odd_byte_enable_n,
    input  wire logic io_read_strobe_n,
    output var  logic battery_detect_a,
    output var  logic battery_detect_b,
    output var  logic card_detect_a,
    output var  logic card_detect_b,
    output var  logic card_ready,
    output var  logic input_acknowledge_n,
    // Bench control
    input  wire logic inserted,
    input  wire logic batt_a,
    input  wire logic batt_b,
    input  wire logic busy,
    input  wire logic ack_able
);
    // Socket pull-ups hold every line high while no card is seated
    assign card_detect_a    = !inserted;
    assign card_detect_b    = !inserted;
    assign battery_detect_a = !inserted || batt_a;
    assign battery_detect_b = !inserted || batt_b;
    assign card_ready       = !inserted || !busy;
    // Acknowledge only while selected and strobed
    assign input_acknowledge_n = !(inserted && ack_able && !io_read_strobe_n
        && !(even_byte_enable_n && odd_byte_enable_n));
endmodule

`default_nettype wire

// ---- tb_card_socket_status_control.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "csc_cfg.svh"

module tb_card_socket_status_control;
    logic        clk_sys;
    logic        arst_n;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rdat;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, resp;
    logic        bvd_a, bvd_b, cd_a, cd_b, rdy, ack_n;
    logic        even_n, odd_n, strobe_n, audio, irq;
    logic        inserted, batt_a, batt_b, busy, ack_able;
    int          n_fail, n_checks, cyc;

    csc_top DUT (.clk_sys(clk_sys), .arst_n(arst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .battery_detect_a(bvd_a), .battery_detect_b(bvd_b), .card_detect_a(cd_a),
        .card_detect_b(cd_b), .card_ready(rdy), .input_acknowledge_n(ack_n),
        .even_byte_enable_n(even_n), .odd_byte_enable_n(odd_n),
        .io_read_strobe_n(strobe_n), .audio_out_bit(audio), .chg_irq(irq));

    csc_card_model card (.even_byte_enable_n(even_n), .odd_byte_enable_n(odd_n),
        .io_read_strobe_n(strobe_n), .battery_detect_a(bvd_a),
        .battery_detect_b(bvd_b), .card_detect_a(cd_a), .card_detect_b(cd_b),
        .card_ready(rdy), .input_acknowledge_n(ack_n), .inserted(inserted),
        .batt_a(batt_a), .batt_b(batt_b), .busy(busy), .ack_able(ack_able));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        bit aw, w;
        aw = 0;
        w  = 0;
        @(posedge clk_sys);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready && !aw) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (wready && !w) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end while (!(aw && w));
        do @(posedge clk_sys); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge clk_sys);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk_sys); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk_sys); while (!rvalid);
        rdat = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic settle;
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic t_detect;
        axr(`CSC_OFF_STATUS);
        chk("detect", {29'h0, rdat[2:0]}, 32'h0000_0004);
        axr(`CSC_OFF_CHANGE);
        chk("detect_chg", {31'h0, rdat[3]}, 32'h0000_0001);
        axw(`CSC_OFF_CHANGE, 32'h0000_000F);
        axr(`CSC_OFF_CHANGE);
        chk("chg_clear", rdat, 32'h0000_0000);
        $display("test detect done");
    endtask

    task automatic t_irq;
        axw(`CSC_OFF_CHG_EN, 32'h0000_0001);
        axr(`CSC_OFF_CHG_EN);
        chk("chg_en_rd", rdat, 32'h0000_0001);
        batt_a <= 1'b0;
        settle();
        chk("irq_set", {31'h0, irq}, 32'h0000_0001);
        axw(`CSC_OFF_CHANGE, 32'h0000_0001);
        settle();
        chk("irq_clear", {31'h0, irq}, 32'h0000_0000);
        axw(`CSC_OFF_CHG_EN, 32'h0000_0000);
        batt_a <= 1'b1;
        settle();
        chk("irq_masked", {31'h0, irq}, 32'h0000_0000);
        axr(`CSC_OFF_CHANGE);
        chk("chg_masked", {31'h0, rdat[0]}, 32'h0000_0001);
        $display("test interrupt done");
    endtask

    task automatic t_battery;
        logic [1:0] code [4] = '{2'b00, 2'b01, 2'b10, 2'b10};
        for (int i = 0; i < 4; i++) begin
            batt_a <= !i[1];
            batt_b <= !i[0];
            settle();
            axr(`CSC_OFF_STATUS);
            chk("battery", {30'h0, rdat[4:3]}, {30'h0, code[i]});
            chk("bvd_bits", {30'h0, rdat[7:6]}, {30'h0, !i[0], !i[1]});
        end
        $display("test battery done");
    endtask

    task automatic t_io_mode;
        axw(`CSC_OFF_CONTROL, 32'h0000_0005);
        settle();
        chk("audio_b0", {31'h0, audio}, 32'h0000_0000);
        batt_b <= 1'b1;
        settle();
        chk("audio_b1", {31'h0, audio}, 32'h0000_0001);
        axr(`CSC_OFF_STATUS);
        chk("alert", {22'h0, rdat[9:8], 6'h0, rdat[4:3]}, 32'h0000_0100);
        axw(`CSC_OFF_CHANGE, 32'h0000_000F);
        batt_a <= 1'b1;
        settle();
        axr(`CSC_OFF_CHANGE);
        chk("alert_chg", rdat, 32'h0000_0001);
        batt_a <= 1'b0;
        settle();
        axw(`CSC_OFF_CONTROL, 32'h0000_0007);
        axr(`CSC_OFF_STATUS);
        chk("ring", {30'h0, rdat[9:8]}, 32'h0000_0002);
        axr(`CSC_OFF_CONTROL);
        chk("control_rd", rdat, 32'h0000_0007);
        axw(`CSC_OFF_CONTROL, 32'h0000_0000);
        settle();
        chk("audio_mem", {31'h0, audio}, 32'h0000_0000);
        $display("test io mode done");
    endtask

    task automatic t_ready;
        batt_a <= 1'b1;
        settle();
        axw(`CSC_OFF_CHANGE, 32'h0000_000F);
        busy <= 1'b1;
        settle();
        axr(`CSC_OFF_STATUS);
        chk("ready_lvl", {31'h0, rdat[5]}, 32'h0000_0000);
        axr(`CSC_OFF_CHANGE);
        chk("ready_chg", rdat, 32'h0000_0004);
        busy <= 1'b0;
        axr(8'h20);
        chk("unmapped_rd", {rdat[29:0], resp}, 32'h0000_0002);
        axw(8'h20, 32'h0000_0001);
        chk("unmapped_wr", {30'h0, resp}, 32'h0000_0002);
        $display("test ready done");
    endtask

    task automatic watch(input logic e_even, input logic e_odd, output int lows);
        lows = 0;
        repeat (40) begin
            @(posedge clk_sys);
            #1;
            if (strobe_n === 1'b0) begin
                lows++;
                chk("even_en", {31'h0, even_n}, {31'h0, e_even});
                chk("odd_en", {31'h0, odd_n}, {31'h0, e_odd});
            end
        end
    endtask

    task automatic t_cycle;
        logic [2:0] cmd [3] = '{3'b100, 3'b101, 3'b110};
        int         lows;
        for (int i = 0; i < 3; i++) begin
            ack_able <= i[0] | i[1];
            fork
                axw(`CSC_OFF_CYCLE, {29'h0, cmd[i]});
                watch(cmd[i][0] && !cmd[i][1], !cmd[i][0] && !cmd[i][1], lows);
            join
            chk("strobe_len", lows, 32'h0000_000A);
            chk("idle_en", {30'h0, even_n, odd_n}, 32'h0000_0003);
            axr(`CSC_OFF_STATUS);
            chk("ack_seen", {31'h0, rdat[11]}, {31'h0, i[0] | i[1]});
            axr(`CSC_OFF_CYCLE);
            chk("cycle_rd", rdat, {30'h0, cmd[i][1:0]});
        end
        $display("test io read cycle done");
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    initial begin
        {arst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        {inserted, batt_a, batt_b, busy, ack_able} = 5'b11100;
        n_fail = 0;
        n_checks = 0;
        cyc = 0;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        settle();
        t_detect();
        t_irq();
        t_battery();
        t_io_mode();
        t_ready();
        t_cycle();
        complete_run();
    end
endmodule

`default_nettype wire
